// >>> ebt_ext_source.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------
// External count pin source
// ------------------------------
module ebt_ext_source
(
	input wire logic hclk,
	input wire logic go,
	input wire logic [7:0] toggles,
	output var logic pin,
	output wire logic busy
);
	logic [2:0] ph = 3'h0;
	logic [7:0] left = 8'h00;
	initial pin = 1'b0;
	// Each level held six clocks, well over the sampling limit
	always @(posedge hclk)
	begin
		if (go)
		begin
			left <= toggles;
			ph <= 3'h0;
		end
		else if (left != 8'h00)
		begin
			ph <= ph + 3'h1;
			if (ph == 3'h5)
			begin
				ph <= 3'h0;
				pin <= ~pin;
				left <= left - 8'h01;
			end
		end
	end
	assign busy = (left != 8'h00);
endmodule
`default_nettype wire

// >>> ebt_timer.v
`timescale 1ns/1ps
`default_nettype none
`include "ebt_timer_consts.vh"

// Functional notes
// - In timer mode with no prescaling the count register advances once per instruction cycle.
// - Source select 0 counts the instruction cycle clock and 1 counts external input transitions.
// - A write to the count register blocks incrementing for the next two instruction cycles.
// - Counter mode advances on one external edge, falling when edge select is 1 and rising when 0.
// - The single prescaler serves the watchdog when the assign bit is 1 and the timer when it is 0.
// - Rate codes 000 to 111 give timer division 1:2 to 1:256, or watchdog division 1:1 to 1:128.
// - The timer runs undivided only while the prescaler belongs to the watchdog.
// - The prescaler is hidden from software and any count register write clears it while timer owned.
// - A watchdog clear instruction clears the prescaler while the watchdog owns it.
// - Rolling the count from FFh to 00h sets the overflow flag whatever the interrupt enable is.
// - The overflow flag stays set until software clears it and interrupts only while enabled.
// - During sleep the timer is frozen, so it cannot wake the processor.
// - In counter mode the prescaler output is sampled on phase Q2 and the count moves at the Q4 that follows.
// - The count register is eight bits wide, readable and writable, holding the current value.
module ebt_timer
(
	input wire hclk,
	input wire hresetn,
	input wire ce,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg [31:0] hrdata,
	output reg hreadyout,
	output reg hresp,
	input wire external_count_input,
	input wire watchdog_clock_tick,
	input wire watchdog_clear_instruction,
	input wire sleep_mode,
	output reg watchdog_prescaled_tick,
	output reg irq
);

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	reg [1:0] q_phase;
	reg dp_valid;
	reg dp_write;
	reg [7:0] dp_addr;
	reg rd_wait;
	reg [7:0] count_register;
	reg [7:0] timer_option_settings;
	reg overflow_irq_enable;
	reg overflow_flag;
	reg [7:0] prescaler;
	reg [1:0] inhibit;
	reg ext_s1;
	reg ext_s2;
	reg ext_s3;
	reg wdg_s1;
	reg wdg_s2;
	reg wdg_s3;
	reg ctr_pend;
	reg ctr_stage;
	reg [31:0] read_value;
	reg next_flag;
	reg next_enable;
	wire q2;
	wire q4;
	wire addr_phase;
	wire wr_go;
	wire wr_count;
	wire wr_option;
	wire wr_intctl;
	wire wr_clear;
	wire wr_enable;
	wire count_source_select;
	wire source_edge_select;
	wire prescaler_assign;
	wire [2:0] prescale_rate;
	wire ext_rise;
	wire ext_fall;
	wire ext_edge;
	wire wd_event;
	wire src_event;
	wire pre_advance;
	wire pre_done;
	wire pre_clear;
	wire timer_pulse;
	wire inc_req;
	wire inc;
	wire ovf_set;
	wire ovf_clr;

	// ----------------------------------------
	// Functions
	// ----------------------------------------

	// True when the low n bits of the prescaler are all ones
	function f_term;
		input [7:0] value;
		input [3:0] n;
		reg [7:0] mask;
		begin
			mask = 8'hFF >> (4'h8 - n);
			f_term = ((value & mask) == mask);
		end
	endfunction

	// ----------------------------------------
	// Option fields and phase decode
	// ----------------------------------------
	assign count_source_select = timer_option_settings[`EBT_OPT_SRC];
	assign source_edge_select = timer_option_settings[`EBT_OPT_EDGE];
	assign prescaler_assign = timer_option_settings[`EBT_OPT_ASSIGN];
	assign prescale_rate = timer_option_settings[`EBT_OPT_RATE_HI:`EBT_OPT_RATE_LO];
	assign q2 = (q_phase == `EBT_PHASE_Q2);
	assign q4 = (q_phase == `EBT_PHASE_Q4); // Last phase ends the instruction cycle

	// Four hclk phases make one instruction cycle
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			q_phase <= 2'h0;
		else if (ce)
			q_phase <= q_phase + 2'h1;
	end

	// ----------------------------------------
	// AHB-Lite slave
	// ----------------------------------------
	assign addr_phase = hsel & htrans[1] & hready;
	assign wr_go = dp_valid & dp_write & hready;
	assign wr_count = wr_go & (dp_addr == `EBT_OFS_COUNT);
	assign wr_option = wr_go & (dp_addr == `EBT_OFS_OPTION);
	assign wr_intctl = wr_go & (dp_addr == `EBT_OFS_INTCTL);
	assign wr_clear = wr_go & (dp_addr == `EBT_OFS_CLEAR);
	assign wr_enable = wr_go & (dp_addr == `EBT_OFS_ENABLE);

	// Reads take one wait state so a write just before is already visible
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			dp_valid <= 1'b0;
			dp_write <= 1'b0;
			dp_addr <= 8'h00;
			rd_wait <= 1'b0;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			hrdata <= 32'h0000_0000;
		end
		else if (ce)
		begin
			if (addr_phase)
			begin
				dp_valid <= 1'b1;
				dp_write <= hwrite;
				dp_addr <= {haddr[7:2], 2'b00};
			end
			else if (hready)
				dp_valid <= 1'b0;
			rd_wait <= addr_phase & ~hwrite;
			hreadyout <= ~(addr_phase & ~hwrite);
			hresp <= 1'b0;
			if (rd_wait)
				hrdata <= read_value;
		end
	end

	// Read mux; unmapped and write-only words read zero
	always @*
	begin
		read_value = 32'h0000_0000;
		case (dp_addr)
			`EBT_OFS_COUNT: read_value = {24'h00_0000, count_register};
			`EBT_OFS_OPTION: read_value = {24'h00_0000, timer_option_settings};
			`EBT_OFS_INTCTL:
			begin
				read_value[`EBT_IC_IRQ_EN] = overflow_irq_enable;
				read_value[`EBT_IC_OVF_FLAG] = overflow_flag;
			end
			`EBT_OFS_STATUS: read_value[`EBT_ST_OVF] = overflow_flag;
			`EBT_OFS_ENABLE: read_value[`EBT_ST_OVF] = overflow_irq_enable;
			default: read_value = 32'h0000_0000;
		endcase
	end

	// ----------------------------------------
	// Input synchronisers and edge detect
	// ----------------------------------------
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ext_s1 <= 1'b0;
			ext_s2 <= 1'b0;
			ext_s3 <= 1'b0;
			wdg_s1 <= 1'b0;
			wdg_s2 <= 1'b0;
			wdg_s3 <= 1'b0;
		end
		else if (ce)
		begin
			ext_s1 <= external_count_input;
			ext_s2 <= ext_s1;
			ext_s3 <= ext_s2;
			wdg_s1 <= watchdog_clock_tick;
			wdg_s2 <= wdg_s1;
			wdg_s3 <= wdg_s2;
		end
	end

	assign ext_rise = ext_s2 & ~ext_s3;
	assign ext_fall = ~ext_s2 & ext_s3;
	assign ext_edge = source_edge_select ? ext_fall : ext_rise;
	assign wd_event = wdg_s2 & ~wdg_s3;

	// ----------------------------------------
	// Shared prescaler
	// ----------------------------------------

	// Timer clock source: instruction cycle or external edge
	assign src_event = count_source_select ? ext_edge : q4;
	// Owner picks what advances the prescaler; never both at once
	assign pre_advance = ~sleep_mode & (prescaler_assign ? wd_event : src_event);
	// Timer division is 2^(rate+1), 1:2 at the lowest code
	assign pre_done = pre_advance & ~prescaler_assign & f_term(prescaler, {1'b0, prescale_rate} + 4'h1);
	// Clears follow the current owner only
	assign pre_clear = prescaler_assign ? watchdog_clear_instruction : wr_count;
	// Undivided only when the watchdog owns the prescaler
	assign timer_pulse = ~sleep_mode & (prescaler_assign ? src_event : pre_done);

	// Prescaler has no bus path; only clears and advances touch it
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			prescaler <= 8'h00;
		else if (ce)
		begin
			if (pre_clear)
				prescaler <= 8'h00;
			else if (pre_advance)
				prescaler <= prescaler + 8'h01;
		end
	end

	// Watchdog side of the prescaler: 2^rate, so 1:1 at code 000
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			watchdog_prescaled_tick <= 1'b0;
		else if (ce)
			watchdog_prescaled_tick <= pre_advance & prescaler_assign & ~pre_clear
				& f_term(prescaler, {1'b0, prescale_rate});
	end

	// ----------------------------------------
	// Counter mode synchronisation
	// ----------------------------------------

	// Prescaler output is caught at Q2 and applied at Q4
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ctr_pend <= 1'b0;
			ctr_stage <= 1'b0;
		end
		else if (ce)
		begin
			if (!count_source_select)
			begin
				ctr_pend <= 1'b0;
				ctr_stage <= 1'b0;
			end
			else if (!sleep_mode)
			begin
				if (q2)
				begin
					ctr_stage <= ctr_pend | timer_pulse;
					ctr_pend <= 1'b0;
				end
				else
				begin
					ctr_pend <= ctr_pend | timer_pulse;
					if (q4)
						ctr_stage <= 1'b0;
				end
			end
		end
	end

	// ----------------------------------------
	// Count register
	// ----------------------------------------
	assign inc_req = count_source_select ? (q4 & ctr_stage) : timer_pulse;
	// Sleep freezes the count, so no overflow can wake the core
	assign inc = inc_req & (inhibit == 2'h0) & ~wr_count & ~sleep_mode;

	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			count_register <= `EBT_RST_COUNT;
			inhibit <= 2'h0;
		end
		else if (ce)
		begin
			if (wr_count)
			begin
				count_register <= hwdata[7:0];
				inhibit <= `EBT_WR_INHIBIT;
			end
			else
			begin
				if (inc)
					count_register <= count_register + 8'h01;
				if (q4 && inhibit != 2'h0 && !sleep_mode)
					inhibit <= inhibit - 2'h1;
			end
		end
	end

	// ----------------------------------------
	// Option register
	// ----------------------------------------
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			timer_option_settings <= `EBT_RST_OPTION;
		else if (ce && wr_option)
			timer_option_settings <= hwdata[7:0];
	end

	// ----------------------------------------
	// Overflow flag and interrupt
	// ----------------------------------------
	assign ovf_set = inc & (count_register == `EBT_COUNT_MAX);
	assign ovf_clr = (wr_intctl & ~hwdata[`EBT_IC_OVF_FLAG]) | (wr_clear & hwdata[`EBT_ST_OVF]);

	// A set in the same cycle as a clear wins so no rollover is lost
	always @*
	begin
		next_flag = ovf_set | (overflow_flag & ~ovf_clr);
		next_enable = overflow_irq_enable;
		if (wr_intctl)
			next_enable = hwdata[`EBT_IC_IRQ_EN];
		else if (wr_enable)
			next_enable = hwdata[`EBT_ST_OVF];
	end

	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			overflow_flag <= 1'b0;
			overflow_irq_enable <= 1'b0;
			irq <= 1'b0;
		end
		else if (ce)
		begin
			overflow_flag <= next_flag;
			overflow_irq_enable <= next_enable;
			irq <= next_flag & next_enable;
		end
	end

endmodule
`default_nettype wire

// >>> ebt_timer_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "ebt_timer_consts.vh"
module ebt_timer_bench;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic wd_clk = 1'b0;
	logic wd_clr = 1'b0;
	logic sleep = 1'b0;
	logic go = 1'b0;
	logic ce = 1'b1;
	logic [7:0] cur_opt = 8'hFF;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0000_0000;
	logic [31:0] hwdata = 32'h0000_0000;
	logic [7:0] toggles = 8'h00;
	logic [16:0] lf = 17'h1_00EE;
	logic [31:0] hrdata, rdv, v, e;
	logic hreadyout, wd_tick, irq, pin, busy, s;
	int failures = 0;
	int n_compared = 0;
	int n_wd = 0;
	logic [7:0] cfg [3] = '{8'h28, 8'h38, 8'h20};
	int tg [3] = '{7, 7, 8};
	ebt_timer u_ebt_timer
	(
		.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(), .external_count_input(pin), .watchdog_clock_tick(wd_clk),
		.watchdog_clear_instruction(wd_clr), .sleep_mode(sleep), .watchdog_prescaled_tick(wd_tick), .irq(irq)
	);
	ebt_ext_source u_ebt_ext_source (.hclk(hclk), .go(go), .toggles(toggles), .pin(pin), .busy(busy));
	// ------------------------------
	// Clock, counters and helpers
	// ------------------------------
	always #25 hclk = ~hclk;
	// Completed watchdog divisions
	always @(posedge hclk)
	begin
		if (wd_tick === 1'b1)
			n_wd <= n_wd + 1;
	end
	function automatic logic [16:0] nxt(input logic [16:0] q);
		return {q[15:0], q[16] ^ q[13]};
	endfunction
	// Active edges in t toggles from level q
	function automatic int edges(input logic q, input logic fall, input int t);
		return (q ^ fall) ? t / 2 : (t + 1) / 2;
	endfunction
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
	begin
		n_compared++;
		if (seen !== exp)
		begin
			failures++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	end
	endtask
	// Single word transfer, read data lands in rdv
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
	begin
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h00_0000, a};
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rdv = hrdata;
	end
	endtask
	task automatic wdg(input int n);
	begin
		repeat (n)
		begin
			repeat (4) @(posedge hclk);
			wd_clk <= 1'b1;
			repeat (4) @(posedge hclk);
			wd_clk <= 1'b0;
		end
		repeat (8) @(posedge hclk);
	end
	endtask
	task automatic wclr;
	begin
		wd_clr <= 1'b1;
		@(posedge hclk);
		wd_clr <= 1'b0;
	end
	endtask
	// Ownership moves keep the safe switch order
	task automatic setopt(input logic [7:0] o);
	begin
		if (o[`EBT_OPT_ASSIGN] && !cur_opt[`EBT_OPT_ASSIGN])
		begin
			wclr();
			bus(1, `EBT_OFS_COUNT, 0);
			bus(1, `EBT_OFS_OPTION, {24'h00_0000, cur_opt | 8'h08});
			wclr();
		end
		else if (!o[`EBT_OPT_ASSIGN] && cur_opt[`EBT_OPT_ASSIGN])
			wclr();
		bus(1, `EBT_OFS_OPTION, {24'h00_0000, o});
		cur_opt = o;
	end
	endtask
	task automatic final_report;
	begin
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	end
	endtask
	// ------------------------------
	// Main sequence
	// ------------------------------
	initial
	begin
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		bus(0, `EBT_OFS_OPTION, 0);
		chk("option", rdv, 32'h0000_00FF);
		bus(0, `EBT_OFS_COUNT, 0);
		chk("count", rdv, 32'h0000_0000);
		bus(1, 8'h18, 32'h0000_00AA);
		bus(0, 8'h18, 0);
		chk("unmapped", rdv, 32'h0000_0000);
		// Every rate, then undivided; reads exactly three periods apart
		for (int r = 0; r < 9; r++)
		begin
			setopt((r == 8) ? 8'h08 : 8'(r));
			bus(1, `EBT_OFS_COUNT, 0);
			repeat (12) @(posedge hclk);
			bus(0, `EBT_OFS_COUNT, 0);
			v = rdv;
			repeat (((r == 8) ? 12 : 24 << r) - 4) @(posedge hclk);
			bus(0, `EBT_OFS_COUNT, 0);
			chk("rate", rdv - v, 32'h0000_0003);
		end
		// Clock enable low freezes phase and count alike
		bus(0, `EBT_OFS_COUNT, 0);
		v = rdv;
		ce <= 1'b0;
		repeat (40) @(posedge hclk);
		ce <= 1'b1;
		repeat (8) @(posedge hclk);
		bus(0, `EBT_OFS_COUNT, 0);
		chk("ce_freeze", rdv - v, 32'h0000_0003);
		// Random start values; ten cycles pass, the first two inhibited
		repeat (4)
		begin
			lf = nxt(lf);
			e = {25'h000_0000, lf[6:0]} + 32'h0000_0008;
			bus(1, `EBT_OFS_COUNT, e - 32'h0000_0008);
			repeat (38) @(posedge hclk);
			bus(0, `EBT_OFS_COUNT, 0);
			chk("inhibit", rdv, e);
		end
		setopt(8'h07);
		repeat (600) @(posedge hclk);
		bus(1, `EBT_OFS_COUNT, 0);
		repeat (896) @(posedge hclk);
		bus(0, `EBT_OFS_COUNT, 0);
		chk("presc_clear", rdv, 32'h0000_0000);
		setopt(8'h08);
		bus(1, `EBT_OFS_ENABLE, 0);
		bus(1, `EBT_OFS_CLEAR, 1);
		bus(1, `EBT_OFS_COUNT, 32'h0000_00FD);
		repeat (40) @(posedge hclk);
		bus(0, `EBT_OFS_STATUS, 0);
		chk("flag", rdv, 32'h0000_0001);
		chk("irq_off", 32'(irq), 32'h0000_0000);
		bus(1, `EBT_OFS_ENABLE, 1);
		repeat (3) @(posedge hclk);
		chk("irq_on", 32'(irq), 32'h0000_0001);
		bus(1, `EBT_OFS_CLEAR, 1);
		repeat (3) @(posedge hclk);
		chk("irq_clr", 32'(irq), 32'h0000_0000);
		bus(1, `EBT_OFS_ENABLE, 0);
		bus(1, `EBT_OFS_COUNT, 32'h0000_00FE);
		sleep <= 1'b1;
		repeat (100) @(posedge hclk);
		bus(0, `EBT_OFS_COUNT, 0);
		chk("sleep_count", rdv, 32'h0000_00FE);
		bus(0, `EBT_OFS_STATUS, 0);
		chk("sleep_flag", rdv, 32'h0000_0000);
		sleep <= 1'b0;
		// Both edges, and the timer owned prescaler at 1:2
		for (int m = 0; m < 3; m++)
		begin
			setopt(cfg[m]);
			bus(1, `EBT_OFS_COUNT, 0);
			repeat (12) @(posedge hclk);
			s = pin;
			go <= 1'b1;
			toggles <= tg[m][7:0];
			@(posedge hclk);
			go <= 1'b0;
			do @(posedge hclk); while (busy);
			repeat (20) @(posedge hclk);
			bus(0, `EBT_OFS_COUNT, 0);
			chk("counter", rdv, edges(s, cfg[m][4], tg[m]) >> !cfg[m][3]);
		end
		setopt(8'h0A);
		wclr();
		v = n_wd;
		wdg(3);
		wclr();
		wdg(3);
		chk("wd_cleared", n_wd - v, 32'h0000_0000);
		wdg(1);
		chk("wd_rate", n_wd - v, 32'h0000_0001);
		final_report();
	end
	// Hang guard, far past the expected span
	initial
	begin
		repeat (40000) @(posedge hclk);
		failures++;
		final_report();
	end
endmodule
`default_nettype wire

// >>> ebt_timer_consts.vh
`ifndef EBT_TIMER_CONSTS_VH
`define EBT_TIMER_CONSTS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define EBT_OFS_COUNT 8'h00
`define EBT_OFS_OPTION 8'h04
`define EBT_OFS_INTCTL 8'h08
`define EBT_OFS_STATUS 8'h0C
`define EBT_OFS_CLEAR 8'h10
`define EBT_OFS_ENABLE 8'h14

// ----------------------------------------
// Field positions
// ----------------------------------------
`define EBT_OPT_SRC 5
`define EBT_OPT_EDGE 4
`define EBT_OPT_ASSIGN 3
`define EBT_OPT_RATE_HI 2
`define EBT_OPT_RATE_LO 0
`define EBT_IC_IRQ_EN 5
`define EBT_IC_OVF_FLAG 2
`define EBT_ST_OVF 0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define EBT_RST_COUNT 8'h00
`define EBT_RST_OPTION 8'hFF

// ----------------------------------------
// Timing
// ----------------------------------------
`define EBT_CLK_NS 50
`define EBT_TCY_NS 200
`define EBT_PHASES (`EBT_TCY_NS / `EBT_CLK_NS)
`define EBT_PHASE_Q2 2'h1
`define EBT_PHASE_Q4 2'h3
`define EBT_WR_INHIBIT 2'h2
`define EBT_COUNT_MAX 8'hFF

`endif

// >>> ebt_timer_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------
// Port checker for the timer
// ------------------------------
module ebt_timer_monitor
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ce,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic watchdog_clock_tick,
	input wire logic sleep_mode,
	input wire logic watchdog_prescaled_tick,
	input wire logic irq
);
	logic acc;
	logic wr;
	// Accepted address phases
	assign acc = ce && hsel && htrans[1] && hready;
	assign wr = acc && hwrite;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	a_resp_okay: assert property (hresp == 1'b0)
		else $error("response not okay");
	a_read_wait: assert property (acc && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");
	a_write_ready: assert property (wr |=> hreadyout)
		else $error("write stalled");
	a_rdata_upper: assert property (!hreadyout ##1 hreadyout |-> hrdata[31:8] == 24'h00_0000)
		else $error("read data upper bits set");
	a_wd_pulse: assert property (watchdog_prescaled_tick |=> !watchdog_prescaled_tick)
		else $error("watchdog tick too long");
	a_wd_quiet: assert property ((!watchdog_clock_tick) [*8] |-> !watchdog_prescaled_tick)
		else $error("watchdog tick without event");
	a_sleep_frozen: assert property ((sleep_mode && !htrans[1]) [*4] |-> !$rose(irq))
		else $error("irq rose while asleep");
	a_irq_fall: assert property ($fell(irq) |-> $past(wr) || $past(wr, 2))
		else $error("irq dropped without a write");
endmodule
bind ebt_timer ebt_timer_monitor u_ebt_timer_monitor (.hclk, .hresetn, .ce, .hsel, .htrans, .hwrite, .hready,
	.hrdata, .hreadyout, .hresp, .watchdog_clock_tick, .sleep_mode, .watchdog_prescaled_tick, .irq);
`default_nettype wire
